// ### verilog/hot_reset_consts.svh
// register offsets, field positions, reset values and timing figures
// assumes inclusion by bare name from the package and the sequencer
`ifndef HOT_RESET_CONSTS_SVH
`define HOT_RESET_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_SWITCH_CONTROL   12'h000
`define OFS_SMBUS_STATUS     12'h004
`define OFS_BRIDGE_CONTROL   12'h008
`define OFS_PHY_LINK_STATE   12'h00C
`define OFS_SEQ_STATUS       12'h010

// ****************************************************************
// field positions
// ****************************************************************
`define CTL_HOT_RESET_REQ    0
`define CTL_LINK_DOWN_DIS    1
`define CTL_EEPROM_INIT_DIS  2
`define CTL_RESET_HALT       3
`define CTL_EEPROM_MODE      4
`define CTL_UNLOCK           5
`define SMB_DONE             0
`define SMB_ERROR            1
`define SMB_CODE_LSB         4
`define BRIDGE_CONTROL_REG_SEC_BUS_RESET   0
`define PHY_RETRAIN_LSB      0
`define PHY_PARAM_LSB        8
`define STS_LOGIC_RESET      0
`define STS_QUASI_RESET      1
`define STS_LOADING          2
`define STS_HALTED           3
`define STS_TRAIN_LATE       4

// ****************************************************************
// reset values
// ****************************************************************
`define RST_EEPROM_MODE      1'b1
`define RST_LINK_PARAM       4'h1
`define RST_ZERO_WORD        32'h0000_0000

// ****************************************************************
// timing
// ****************************************************************
`define CLOCK_MHZ            125
`define TRAIN_DEADLINE_MS    20
`define CFG_READY_MS         100
`define CYCLES_PER_MS        (`CLOCK_MHZ * 1000)

`endif

// ### verilog/hot_reset_pkg.sv
// types shared by the hot reset sequencer and its environment
// assumes the constants header sits beside it
package hot_reset_pkg;
  `include "hot_reset_consts.svh"

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    st_idle,
    st_propagate,
    st_apply,
    st_quasi,
    st_load,
    st_halt
  } seq_state_t;

  // ****************************************************************
  // bus and loader carriers
  // ****************************************************************
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] addr;
    logic [31:0] data;
  } eeprom_wr_t;
endpackage : hot_reset_pkg

// ### verilog/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
// assumes inputs asynchronous to clock
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  if (WIDTH < 1) begin : g_check
    $error("pin_sync3 width must be at least one");
  end

  // ****************************************************************
  // chain, output follows once stage two and three agree
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      level_out  <= '0;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          level_out[i] <= stage3_reg[i];
        end
      end
    end
  end
endmodule : pin_sync3

// ### verilog/switch_hot_reset_sequencer.sv
// hot reset and upstream secondary bus reset sequencer of a switch
// assumes an apb master, an eeprom loader on the same clock, phy pins async
`timescale 1ns/1ps
`include "hot_reset_consts.svh"
module switch_hot_reset_sequencer
  import hot_reset_pkg::*;
#(
  parameter int PORTS        = 3,
  parameter int DS_PORTS     = 2,
  parameter int TRAIN_CYCLES = `TRAIN_DEADLINE_MS * `CYCLES_PER_MS,
  parameter int CFG_CYCLES   = `CFG_READY_MS * `CYCLES_PER_MS
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire apb_req_t            apb_req,
  output apb_rsp_t                 apb_rsp,
  input  wire logic                ts1_hot_reset_rx,
  input  wire logic                us_dl_down,
  input  wire logic [PORTS-1:0]    training_active,
  input  wire logic [DS_PORTS-1:0] ds_link_up,
  input  wire eeprom_wr_t          eeprom_wr,
  input  wire logic                eeprom_done,
  input  wire logic                eeprom_error,
  input  wire logic [3:0]          eeprom_error_code,
  output logic                     eeprom_wr_ack,
  output logic                     eeprom_load_enable,
  output logic                     logic_reset,
  output logic                     quasi_reset,
  output logic                     link_train_enable,
  output logic [DS_PORTS-1:0]      ds_hot_reset_ts1,
  output logic [PORTS-1:0]         link_retrain,
  output logic                     ds_port_reset,
  output logic                     ds_discard_queued,
  output logic                     us_secondary_ur
);
  localparam int CNT_W = $clog2(TRAIN_CYCLES + 1);

  if (DS_PORTS < 1 || DS_PORTS >= PORTS || PORTS > 4) begin : g_ports_check
    $error("port counts not supported");
  end
  if (TRAIN_CYCLES < 1 || TRAIN_CYCLES > CFG_CYCLES) begin : g_time_check
    $error("training deadline must be positive and before config ready");
  end

  seq_state_t          state_reg;
  seq_state_t          state_next;
  logic                pready_reg;
  logic                pslverr_reg;
  logic [31:0]         prdata_reg;
  logic [31:0]         read_word;
  logic                read_hit;
  logic                hot_req_reg;
  logic                link_down_dis_reg;
  logic                eeprom_dis_reg;
  logic                reset_halt_reg;
  logic                eeprom_mode_reg;
  logic                unlock_reg;
  logic                smb_done_reg;
  logic                smb_error_reg;
  logic [3:0]          smb_code_reg;
  logic                sec_bus_reset_reg;
  logic [3:0]          link_param_reg;
  logic                train_late_reg;
  logic [CNT_W-1:0]    train_cnt_reg;
  logic                dl_down_prev_reg;
  logic                ts1_s;
  logic                dl_down_s;
  logic [PORTS-1:0]    training_s;
  logic [DS_PORTS-1:0] link_up_s;
  logic                access;
  logic                wr_commit;
  logic                ld_accept;
  logic                wr_en;
  logic [11:0]         wr_addr;
  logic [31:0]         wr_data;
  logic                start_event;
  logic                hold_trigger;
  logic                apply;
  logic                load_end;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  pin_sync3 #(
    .WIDTH (2 + PORTS + DS_PORTS)
  ) u_pin_sync (
    .clock     (clock),
    .rst       (rst),
    .pin_in    ({ts1_hot_reset_rx, us_dl_down, training_active, ds_link_up}),
    .level_out ({ts1_s, dl_down_s, training_s, link_up_s})
  );

  // ****************************************************************
  // apb slave, one wait state, write lands with pready
  // ****************************************************************
  assign access    = apb_req.psel & apb_req.penable;
  assign wr_commit = access & pready_reg & apb_req.pwrite;
  assign ld_accept = eeprom_wr.valid & ~eeprom_wr_ack & ~wr_commit & (state_reg == st_load);
  assign wr_en     = wr_commit | ld_accept;
  assign wr_addr   = wr_commit ? apb_req.paddr : eeprom_wr.addr;
  assign wr_data   = wr_commit ? apb_req.pwdata : eeprom_wr.data;
  assign apply     = (state_reg == st_apply);
  assign load_end  = (state_reg == st_load) & (eeprom_done | eeprom_error);

  assign apb_rsp.pready  = pready_reg;
  assign apb_rsp.pslverr = pslverr_reg;
  assign apb_rsp.prdata  = prdata_reg;

  always_comb begin
    read_word = `RST_ZERO_WORD;
    read_hit  = 1'b1;
    case (apb_req.paddr)
      `OFS_SWITCH_CONTROL: begin
        read_word[`CTL_LINK_DOWN_DIS]   = link_down_dis_reg;
        read_word[`CTL_EEPROM_INIT_DIS] = eeprom_dis_reg;
        read_word[`CTL_RESET_HALT]      = reset_halt_reg;
        read_word[`CTL_EEPROM_MODE]     = eeprom_mode_reg;
        read_word[`CTL_UNLOCK]          = unlock_reg;
      end
      `OFS_SMBUS_STATUS: begin
        read_word[`SMB_DONE]                    = smb_done_reg;
        read_word[`SMB_ERROR]                   = smb_error_reg;
        read_word[`SMB_CODE_LSB +: 4]           = smb_code_reg;
      end
      `OFS_BRIDGE_CONTROL: begin
        read_word[`BRIDGE_CONTROL_REG_SEC_BUS_RESET] = sec_bus_reset_reg;
      end
      `OFS_PHY_LINK_STATE: begin
        read_word[`PHY_PARAM_LSB +: 4] = link_param_reg;
      end
      `OFS_SEQ_STATUS: begin
        read_word[`STS_LOGIC_RESET] = logic_reset;
        read_word[`STS_QUASI_RESET] = quasi_reset;
        read_word[`STS_LOADING]     = eeprom_load_enable;
        read_word[`STS_HALTED]      = (state_reg == st_halt) & reset_halt_reg;
        read_word[`STS_TRAIN_LATE]  = train_late_reg;
      end
      default: begin
        read_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= `RST_ZERO_WORD;
    end else begin
      pready_reg <= access & ~pready_reg;
      if (access & ~pready_reg) begin
        pslverr_reg <= ~read_hit;
        prdata_reg  <= apb_req.pwrite ? `RST_ZERO_WORD : read_word;
      end else begin
        pslverr_reg <= 1'b0;
        prdata_reg  <= `RST_ZERO_WORD;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      eeprom_wr_ack <= 1'b0;
    end else begin
      eeprom_wr_ack <= ld_accept;
    end
  end

  // ****************************************************************
  // switch control
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hot_req_reg <= 1'b0;
    end else begin
      // fires the cycle after pready, so the completion is out first
      hot_req_reg <= wr_commit & (apb_req.paddr == `OFS_SWITCH_CONTROL)
                     & apb_req.pwdata[`CTL_HOT_RESET_REQ];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link_down_dis_reg <= 1'b0;
      eeprom_dis_reg    <= 1'b0;
      eeprom_mode_reg   <= `RST_EEPROM_MODE;
    end else if (wr_en && wr_addr == `OFS_SWITCH_CONTROL) begin
      link_down_dis_reg <= wr_data[`CTL_LINK_DOWN_DIS];
      eeprom_dis_reg    <= wr_data[`CTL_EEPROM_INIT_DIS];
      eeprom_mode_reg   <= wr_data[`CTL_EEPROM_MODE];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      unlock_reg <= 1'b0;
    end else if (apply) begin
      unlock_reg <= 1'b0;
    end else if (wr_en && wr_addr == `OFS_SWITCH_CONTROL) begin
      unlock_reg <= wr_data[`CTL_UNLOCK];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reset_halt_reg <= 1'b0;
    end else if ((state_reg == st_load) && eeprom_error) begin
      reset_halt_reg <= 1'b1;
    end else if (apply) begin
      reset_halt_reg <= 1'b0;
    end else if (wr_en && wr_addr == `OFS_SWITCH_CONTROL
                 && !wr_data[`CTL_RESET_HALT]) begin
      reset_halt_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // smbus status, sticky, write one to clear
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      smb_done_reg  <= 1'b0;
      smb_error_reg <= 1'b0;
      smb_code_reg  <= 4'h0;
    end else begin
      if (load_end) begin
        smb_done_reg <= 1'b1;
      end else if (wr_commit && apb_req.paddr == `OFS_SMBUS_STATUS
                   && apb_req.pwdata[`SMB_DONE]) begin
        smb_done_reg <= 1'b0;
      end
      if ((state_reg == st_load) && eeprom_error) begin
        smb_error_reg <= 1'b1;
        smb_code_reg  <= eeprom_error_code;
      end else if (wr_commit && apb_req.paddr == `OFS_SMBUS_STATUS
                   && apb_req.pwdata[`SMB_ERROR]) begin
        smb_error_reg <= 1'b0;
        smb_code_reg  <= 4'h0;
      end
    end
  end

  // ****************************************************************
  // bridge control and link state
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sec_bus_reset_reg <= 1'b0;
    end else if (apply) begin
      sec_bus_reset_reg <= 1'b0;
    end else if (wr_en && wr_addr == `OFS_BRIDGE_CONTROL) begin
      sec_bus_reset_reg <= wr_data[`BRIDGE_CONTROL_REG_SEC_BUS_RESET];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link_param_reg <= `RST_LINK_PARAM;
    end else if (wr_en && wr_addr == `OFS_PHY_LINK_STATE && unlock_reg) begin
      link_param_reg <= wr_data[`PHY_PARAM_LSB +: 4]; // kept across resets
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link_retrain <= '0;
    end else if (wr_en && wr_addr == `OFS_PHY_LINK_STATE) begin
      link_retrain <= wr_data[`PHY_RETRAIN_LSB +: PORTS];
    end else begin
      link_retrain <= '0;
    end
  end

  // ****************************************************************
  // trigger collection
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dl_down_prev_reg <= 1'b0;
    end else begin
      dl_down_prev_reg <= dl_down_s;
    end
  end

  // link down fires on its edge so a retraining upstream cannot loop us
  assign start_event  = ts1_s | hot_req_reg
                        | (dl_down_s & ~dl_down_prev_reg & ~link_down_dis_reg);
  assign hold_trigger = ts1_s | hot_req_reg;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_idle: begin
        if (start_event) begin
          state_next = st_propagate;
        end
      end
      st_propagate: begin
        if (!hold_trigger) begin
          state_next = st_apply;
        end
      end
      st_apply: begin
        state_next = st_quasi;
      end
      st_quasi: begin
        if (eeprom_mode_reg && !eeprom_dis_reg) begin
          state_next = st_load;
        end else begin
          state_next = st_halt;
        end
      end
      st_load: begin
        if (eeprom_done || eeprom_error) begin
          state_next = st_halt;
        end
      end
      st_halt: begin
        if (!reset_halt_reg) begin
          state_next = st_idle;
        end
      end
      default: begin
        state_next = st_idle;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= st_idle;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      logic_reset        <= 1'b0;
      quasi_reset        <= 1'b0;
      link_train_enable  <= 1'b0;
      eeprom_load_enable <= 1'b0;
    end else begin
      logic_reset <= (state_next == st_propagate) || (state_next == st_apply)
                     || ((state_next == st_halt) && reset_halt_reg);
      quasi_reset <= (state_next == st_quasi) || (state_next == st_load)
                     || (state_next == st_halt);
      link_train_enable <= (state_next == st_quasi) || (state_next == st_load)
                           || (state_next == st_halt);
      // dropping the enable on error is the abort to the loader
      eeprom_load_enable <= (state_next == st_load) && !eeprom_error;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ds_hot_reset_ts1 <= '0;
    end else if ((state_next == st_propagate) || sec_bus_reset_reg) begin
      ds_hot_reset_ts1 <= link_up_s;
    end else begin
      ds_hot_reset_ts1 <= '0;
    end
  end

  // ****************************************************************
  // upstream secondary bus reset effects
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ds_port_reset     <= 1'b0;
      ds_discard_queued <= 1'b0;
      us_secondary_ur   <= 1'b0;
    end else begin
      ds_port_reset     <= sec_bus_reset_reg;
      ds_discard_queued <= sec_bus_reset_reg;
      us_secondary_ur   <= sec_bus_reset_reg;
    end
  end

  // ****************************************************************
  // training deadline watch
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      train_cnt_reg <= '0;
    end else if (apply) begin
      train_cnt_reg <= '0;
    end else if (link_train_enable && train_cnt_reg != CNT_W'(TRAIN_CYCLES)) begin
      train_cnt_reg <= train_cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      train_late_reg <= 1'b0;
    end else if (link_train_enable && train_cnt_reg == CNT_W'(TRAIN_CYCLES - 1)
                 && !(&training_s)) begin
      train_late_reg <= 1'b1;
    end else if (wr_commit && apb_req.paddr == `OFS_SEQ_STATUS
                 && apb_req.pwdata[`STS_TRAIN_LATE]) begin
      train_late_reg <= 1'b0;
    end
  end
endmodule : switch_hot_reset_sequencer

// ### dv/hot_reset_sva.sv
// assertions on the hot reset sequencer ports
// assumes bind onto switch_hot_reset_sequencer, one clock domain
`timescale 1ns/1ps
module hot_reset_sva
  import hot_reset_pkg::*;
#(
  parameter int PORTS    = 3,
  parameter int DS_PORTS = 2
) (
  input wire logic                clock,
  input wire logic                rst,
  input wire apb_req_t            apb_req,
  input wire apb_rsp_t            apb_rsp,
  input wire logic                ts1_hot_reset_rx,
  input wire eeprom_wr_t          eeprom_wr,
  input wire logic                eeprom_done,
  input wire logic                eeprom_error,
  input wire logic                eeprom_wr_ack,
  input wire logic                eeprom_load_enable,
  input wire logic                logic_reset,
  input wire logic                quasi_reset,
  input wire logic                link_train_enable,
  input wire logic [DS_PORTS-1:0] ds_hot_reset_ts1,
  input wire logic [PORTS-1:0]    link_retrain,
  input wire logic                ds_port_reset,
  input wire logic                ds_discard_queued,
  input wire logic                us_secondary_ur
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_apb_wait_state: assert property ($rose(apb_req.penable) && apb_req.psel |=> apb_rsp.pready)
    else $error("pready not in second access cycle");
  a_apb_rsp_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  a_quasi_trains: assert property (quasi_reset |-> link_train_enable)
    else $error("quasi reset without training");
  a_quasi_after_apply: assert property ($rose(quasi_reset) |-> $past(logic_reset))
    else $error("quasi reset not after reset apply");
  a_ts1_starts: assert property ($rose(ts1_hot_reset_rx) && !logic_reset && !quasi_reset
    |-> ##[1:8] logic_reset)
    else $error("ts1 did not start reset");
  a_ts1_cause: assert property (|ds_hot_reset_ts1 |-> logic_reset || ds_port_reset)
    else $error("hot reset ts1 without reset");
  a_bus_reset_group: assert property (ds_port_reset == ds_discard_queued
    && ds_port_reset == us_secondary_ur)
    else $error("bus reset outputs disagree");
  a_ack_cause: assert property (eeprom_wr_ack |-> $past(eeprom_wr.valid) ##1 !eeprom_wr_ack)
    else $error("loader ack without write");
  a_error_halts: assert property (eeprom_load_enable && eeprom_error
    |=> !eeprom_load_enable ##[0:2] logic_reset)
    else $error("loader error did not abort and halt");
  a_done_no_halt: assert property (eeprom_load_enable && eeprom_done && !eeprom_error
    |=> !logic_reset [*4])
    else $error("halt without loader error");
  a_retrain_pulse: assert property (|link_retrain |=> link_retrain == '0)
    else $error("retrain longer than one cycle");
endmodule : hot_reset_sva

bind switch_hot_reset_sequencer hot_reset_sva #(.PORTS(PORTS), .DS_PORTS(DS_PORTS)) u_sva (
  .clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .ts1_hot_reset_rx(ts1_hot_reset_rx), .eeprom_wr(eeprom_wr), .eeprom_done(eeprom_done),
  .eeprom_error(eeprom_error), .eeprom_wr_ack(eeprom_wr_ack),
  .eeprom_load_enable(eeprom_load_enable), .logic_reset(logic_reset),
  .quasi_reset(quasi_reset), .link_train_enable(link_train_enable),
  .ds_hot_reset_ts1(ds_hot_reset_ts1), .link_retrain(link_retrain),
  .ds_port_reset(ds_port_reset), .ds_discard_queued(ds_discard_queued),
  .us_secondary_ur(us_secondary_ur)
);

// ### dv/eeprom_loader_model.sv
// loader and link training stand-in for the far side
// assumes the sequencer clock, one retrain write per load
`timescale 1ns/1ps
module eeprom_loader_model
  import hot_reset_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rst,
  input  wire logic  load_enable,
  input  wire logic  wr_ack,
  input  wire logic  train_enable,
  input  wire logic  fail,
  output eeprom_wr_t wr,
  output logic       done,
  output logic       error,
  output logic [3:0] code,
  output logic [2:0] train
);
  logic [1:0] step;
  // ****
  // load sequence, released bus shows junk
  // ****
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr <= '{1'b0, 12'hFF3, 32'hFFFF_FFFE};
      {done, error, code, step} <= '0;
    end else begin
      done <= 1'b0;
      error <= 1'b0;
      if (!load_enable) begin
        step <= 2'd0;
      end else if (step == 2'd0) begin
        wr <= '{1'b1, 12'h00C, 32'h0000_0001};
        step <= 2'd1;
      end else if (step == 2'd1 && wr_ack) begin
        wr <= '{1'b0, 12'hFF3, 32'hFFFF_FFFE};
        step <= 2'd2;
      end else if (step == 2'd2) begin
        done <= !fail;
        error <= fail;
        code <= 4'h5;
        step <= 2'd3;
      end
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      train <= '0;
    end else begin
      train <= {3{train_enable}};
    end
  end
endmodule : eeprom_loader_model

// ### dv/switch_hot_reset_sequencer_test.sv
// self-checking bench for the hot reset sequencer
// assumes loader model and checker compiled before it
`timescale 1ns/1ps
module switch_hot_reset_sequencer_test
  import hot_reset_pkg::*;
;
  logic        clock, rst, ts1, dl_down, fail, done, error, ack, load_en;
  logic        lreset, quasi, tren, sbr, discard, ur, pe;
  logic [1:0]  link_up, ts1_out;
  logic [2:0]  train, retrain;
  logic [3:0]  code;
  logic [31:0] rd;
  apb_req_t    req;
  apb_rsp_t    rsp;
  eeprom_wr_t  wr;
  int          err_total, num_checks;

  switch_hot_reset_sequencer #(.TRAIN_CYCLES(20), .CFG_CYCLES(100)) dut (
    .clock(clock), .rst(rst), .apb_req(req), .apb_rsp(rsp), .ts1_hot_reset_rx(ts1),
    .us_dl_down(dl_down), .training_active(train), .ds_link_up(link_up), .eeprom_wr(wr),
    .eeprom_done(done), .eeprom_error(error), .eeprom_error_code(code),
    .eeprom_wr_ack(ack), .eeprom_load_enable(load_en), .logic_reset(lreset),
    .quasi_reset(quasi), .link_train_enable(tren), .ds_hot_reset_ts1(ts1_out),
    .link_retrain(retrain), .ds_port_reset(sbr), .ds_discard_queued(discard),
    .us_secondary_ur(ur));
  eeprom_loader_model far (
    .clock(clock), .rst(rst), .load_enable(load_en), .wr_ack(ack), .train_enable(tren),
    .fail(fail), .wr(wr), .done(done), .error(error), .code(code), .train(train));

  // ****
  // shared tasks
  // ****
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rd = rsp.prdata;
    pe = rsp.pslverr;
    req <= '0;
    if (n >= 50) check("apb_wait", 0, 1);
  endtask : apb
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 400) begin
      @(negedge clock);
      n++;
    end
    check("wait_level", s, v);
  endtask : wait_for
  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask : settle

  // ****
  // scenarios
  // ****
  task automatic s_regs;
    apb(0, 12'h000, 0);
    check("ctrl_reset", rd, 32'h0000_0010);
    apb(0, 12'h00C, 0);
    check("phy_reset", rd, 32'h0000_0100);
    apb(0, 12'h020, 0);
    check("unmapped", pe, 1);
  endtask : s_regs
  task automatic s_software;
    apb(1, 12'h000, 32'h0000_0035);
    settle(1);
    check("early_reset", lreset, 0);
    wait_for(lreset, 1);
    check("ts1_out", ts1_out, link_up);
    wait_for(quasi, 1);
    check("train_en", tren, 1);
    check("no_load", load_en, 0);
    wait_for(quasi, 0);
    apb(0, 12'h000, 0);
    check("ctrl_kept", rd, 32'h0000_0014);
  endtask : s_software
  task automatic s_link_down;
    apb(1, 12'h000, 32'h0000_0016);
    dl_down <= 1'b1;
    settle(12);
    check("masked", lreset, 0);
    @(posedge clock);
    ts1 <= 1'b1;
    wait_for(lreset, 1);
    @(posedge clock);
    ts1 <= 1'b0;
    dl_down <= 1'b0;
    wait_for(quasi, 1);
    wait_for(quasi, 0);
    apb(1, 12'h000, 32'h0000_0014);
    dl_down <= 1'b1;
    @(posedge clock);
    ts1 <= 1'b1;
    settle(5);
    check("dl_first", lreset, 1);
    settle(10);
    check("held", quasi, 0);
    @(posedge clock);
    ts1 <= 1'b0;
    wait_for(quasi, 1);
    wait_for(quasi, 0);
    settle(10);
    check("single_run", lreset, 0);
    @(posedge clock);
    dl_down <= 1'b0;
  endtask : s_link_down
  task automatic s_eeprom(input logic f, input logic [31:0] smb);
    int n;
    logic hit;
    hit = 0;
    fail <= f;
    apb(1, 12'h000, 32'h0000_0011);
    wait_for(load_en, 1);
    for (n = 0; n < 20; n++) begin
      @(negedge clock);
      hit = hit | retrain[0];
    end
    check("retrain", hit, 1);
    wait_for(load_en, 0);
    settle(6);
    check("halt_hold", lreset, f);
    apb(0, 12'h004, 0);
    check("smb_status", rd, smb);
    if (f) begin
      apb(0, 12'h000, 0);
      check("halt_bit", rd[3], 1);
      apb(1, 12'h000, 32'h0000_0010);
    end
    wait_for(lreset, 0);
    wait_for(quasi, 0);
    apb(1, 12'h004, 32'h0000_0003);
  endtask : s_eeprom
  task automatic s_bus_reset;
    apb(1, 12'h008, 32'h0000_0001);
    settle(2);
    check("bus_reset", {sbr, discard, ur}, 3'b111);
    check("bus_ts1", ts1_out, link_up);
    apb(1, 12'h008, 32'h0000_0000);
    settle(2);
    check("bus_resume", {sbr, discard, ur}, 3'b000);
  endtask : s_bus_reset

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  initial begin
    {rst, req, ts1, dl_down, fail, link_up} = {1'b1, 47'd0, 3'd0, 2'b01};
    {err_total, num_checks} = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    s_regs;
    s_software;
    s_link_down;
    s_eeprom(0, 32'h0000_0001);
    s_eeprom(1, 32'h0000_0053);
    s_bus_reset;
    final_report;
  end
  initial begin
    #100us;
    err_total++;
    final_report;
  end
endmodule : switch_hot_reset_sequencer_test
